// File: cap_csr_defs.vh
// Constants for the capability-width CSR bank
`ifndef CAP_CSR_DEFS_VH
`define CAP_CSR_DEFS_VH

`define XLEN 32
`define CAP_WIDTH 64
`define CAP_ENTRIES 14

// Feature straps of this core
`define LEGACY_PRESENT 1'b1
`define VADDR_BITS 31

// CSR addresses
`define ADDR_JUMP_TABLE_BASE_CAP 12'h017
`define ADDR_MACHINE_TRAP_VECTOR_CAP 12'h030
`define ADDR_SUPERVISOR_TRAP_VECTOR_CAP 12'h105
`define ADDR_SUPERVISOR_SCRATCH_CAP 12'h140
`define ADDR_SUPERVISOR_EXCEPTION_PC_CAP 12'h141
`define ADDR_SUPERVISOR_TRAP_DATA_CAP 12'h163
`define ADDR_MACHINE_SCRATCH_CAP 12'h340
`define ADDR_MACHINE_EXCEPTION_PC_CAP 12'h341
`define ADDR_DEFAULT_DATA_CAP 12'h416
`define ADDR_MACHINE_TRAP_DATA_CAP 12'h74c
`define ADDR_DEBUG_PC_CAP 12'h7b1
`define ADDR_DEBUG_SCRATCH0_CAP 12'h7b2
`define ADDR_DEBUG_SCRATCH1_CAP 12'h7b3
`define ADDR_DEBUG_SAVED_DATA_CAP 12'h7bc
`define ADDR_DEBUG_INFINITE_SOURCE_CAP 12'h7bd

// Storage indices
`define IDX_JVT 4'h0
`define IDX_MTVEC 4'h1
`define IDX_STVEC 4'h2
`define IDX_SSCRATCH 4'h3
`define IDX_SEPC 4'h4
`define IDX_STDC 4'h5
`define IDX_MSCRATCH 4'h6
`define IDX_MEPC 4'h7
`define IDX_DDC 4'h8
`define IDX_MTDC 4'h9
`define IDX_DPC 4'ha
`define IDX_DSCRATCH0 4'hb
`define IDX_DSCRATCH1 4'hc
`define IDX_DDDC 4'hd
`define IDX_DINF 4'he
`define IDX_NONE 4'hf

// Capability field layout
`define CAP_ADDR_MSB 31
`define CAP_BASE_MSB 45
`define CAP_BASE_LSB 32
`define CAP_EXP_MSB 50
`define CAP_EXP_LSB 46
`define CAP_SEALED_BIT 51
`define CAP_MODE_BIT 55
`define CAP_EXEC_PERM_BIT 61
`define CAP_SYSREG_PERM_BIT 62
`define CAP_EXP_FULL 5'h1f
`define CAP_RESERVED_MASK 64'h8070_0000_0000_0000
`define CAP_INFINITE 64'h7f07_c000_0000_0000

// Trap vector mode and highest vector offset in bytes
`define TVEC_MODE_VECTORED 2'h1
`define HIGHEST_CAUSE_NUMBER 16
`define VEC_MAX_OFFSET 32'h0000_0100

// CSR operation codes and privilege levels
`define CSR_OP_RW 3'h1
`define CSR_OP_RS 3'h2
`define CSR_OP_RC 3'h3
`define CSR_OP_RWI 3'h5
`define CSR_OP_RSI 3'h6
`define CSR_OP_RCI 3'h7
`define PRIV_U 2'h0
`define PRIV_S 2'h1
`define PRIV_M 2'h3

// Checked instruction kinds
`define INSTR_NONE 3'h0
`define INSTR_SRET 3'h1
`define INSTR_CBO 3'h2
`define INSTR_MODE_SET 3'h3
`define INSTR_MODE_SWITCH 3'h4

// Return target selects
`define RET_MACHINE 2'h0
`define RET_SUPERVISOR 2'h1
`define RET_DEBUG 2'h2

`endif

// File: cap_addr_replace.v
// Invalid address conversion followed by the address replace operation
`include "cap_csr_defs.vh"

module cap_addr_replace (
    srcTag,
    srcCap,
    newAddr,
    convertEn,
    resultTag,
    resultCap,
    addrChanged
);
    input wire srcTag;
    input wire [`CAP_WIDTH-1:0] srcCap;
    input wire [`XLEN-1:0] newAddr;
    input wire convertEn;
    output wire resultTag;
    output wire [`CAP_WIDTH-1:0] resultCap;
    output wire addrChanged;

    wire topValid = newAddr[`VADDR_BITS-1];
    wire [`XLEN-1:0] convAddr;
    wire [`XLEN:0] base;
    wire [`XLEN:0] top;
    wire full;
    wire inBounds;

    // Addresses beyond the stored bits are made canonical
    assign convAddr = convertEn ?
        {{(`XLEN-`VADDR_BITS){topValid}}, newAddr[`VADDR_BITS-1:0]} : newAddr;
    assign addrChanged = convAddr != newAddr;

    assign full = srcCap[`CAP_EXP_MSB:`CAP_EXP_LSB] == `CAP_EXP_FULL;
    assign base = {1'b0, srcCap[`CAP_BASE_MSB:`CAP_BASE_LSB], 18'h0};
    assign top = base + ({{`XLEN{1'b0}}, 1'b1} << srcCap[`CAP_EXP_MSB:`CAP_EXP_LSB]);
    assign inBounds = full || (({1'b0, convAddr} >= base) && ({1'b0, convAddr} < top));

    // Tag lost when sealed or the address leaves the representable range
    assign resultTag = srcTag && inBounds && !srcCap[`CAP_SEALED_BIT];
    assign resultCap = {srcCap[`CAP_WIDTH-1:`XLEN], convAddr};
endmodule

// File: vec_range_check.v
// Vectored trap entry bounds check for trap-vector capabilities
`include "cap_csr_defs.vh"

module vec_range_check (
    vecCap,
    inRange
);
    input wire [`CAP_WIDTH-1:0] vecCap;
    output wire inRange;

    wire [`XLEN:0] base;
    wire [`XLEN:0] top;
    wire [`XLEN:0] lowEntry;
    wire [`XLEN:0] highEntry;
    wire full;

    assign full = vecCap[`CAP_EXP_MSB:`CAP_EXP_LSB] == `CAP_EXP_FULL;
    assign base = {1'b0, vecCap[`CAP_BASE_MSB:`CAP_BASE_LSB], 18'h0};
    assign top = base + ({{`XLEN{1'b0}}, 1'b1} << vecCap[`CAP_EXP_MSB:`CAP_EXP_LSB]);
    assign lowEntry = {1'b0, vecCap[`CAP_ADDR_MSB:2], 2'h0};
    assign highEntry = lowEntry + {1'b0, `VEC_MAX_OFFSET};

    // Offset zero and the highest cause offset must both fall inside
    assign inRange = full || ((lowEntry >= base) && (highEntry < top)); // [R6]
endmodule

// File: capability_width_csr_bank.v
// Capability-width CSR bank: storage, write actions, read legalising and illegal checks
// How it works
// R1: Scratch registers: narrow write replaces address only, wide write stores value unchanged.
// R2: Exception and debug PC, jump table: narrow write converts then always replaces address.
// R3: Same registers, wide write: converted result if address changed, else direct.
// R4: Trap vectors: any width converts and replaces address, mode bits inside address.
// R5: Vectored mode written to trap vector triggers handler entry bounds check.
// R6: Check covers offset zero and highest cause offset.
// R7: Narrow writes to extended registers exist only with legacy mode.
// R8: Exception PC reads are legalised for current compressed enable, bit 1 masked.
// R9: Plain read-write makes narrow or wide access by alias named.
// R10: Set, clear and immediate forms are always narrow accesses.
// R11: Vector registers pass every write through invalid address conversion.
// R12: Scratch and infinite source keep all bits; others drop reserved bits.
// R13: Exception and debug PC targets are unsealed when executed.
// R14: Infinite source reads maximal capability in debug mode, writes ignored.
// R15: Saved data gets default data on debug entry, restored on exit.
// R16: No mode bit without legacy; mode set and switch then illegal.
// R17: Supervisor return illegal below S, without permission, or trapped in S.
// R18: Cache block ops illegal below M or S when matching enable bit clear.
// R19: Missing privilege or system-register permission is illegal, register untouched.
// R20: Reset clears scratch tags; exception PC, vector and default data get maximal capability.
`include "cap_csr_defs.vh"

module capability_width_csr_bank (
    clock,
    rst,
    priv,
    debugMode,
    pccSysRegPerm,
    compressedEnable,
    csrValid,
    csrAddr,
    csrOp,
    csrWide,
    csrWriteEn,
    csrWtag,
    csrWdata,
    csrDone,
    csrIllegal,
    csrRtag,
    csrRdata,
    instrValid,
    instrKind,
    trapSupervisorReturn,
    machineCacheBlockInvalidateEnable,
    supervisorCacheBlockInvalidateEnable,
    instrIllegal,
    debugEntry,
    debugExit,
    retValid,
    retSel,
    retTargetValid,
    retTargetTag,
    retTargetCap,
    ddcTag,
    ddcCap
);
    input wire clock;
    input wire rst;
    input wire [1:0] priv;
    input wire debugMode;
    input wire pccSysRegPerm;
    input wire compressedEnable;
    input wire csrValid;
    input wire [11:0] csrAddr;
    input wire [2:0] csrOp;
    input wire csrWide;
    input wire csrWriteEn;
    input wire csrWtag;
    input wire [`CAP_WIDTH-1:0] csrWdata;
    output reg csrDone;
    output reg csrIllegal;
    output reg csrRtag;
    output reg [`CAP_WIDTH-1:0] csrRdata;
    input wire instrValid;
    input wire [2:0] instrKind;
    input wire trapSupervisorReturn;
    input wire machineCacheBlockInvalidateEnable;
    input wire supervisorCacheBlockInvalidateEnable;
    output reg instrIllegal;
    input wire debugEntry;
    input wire debugExit;
    input wire retValid;
    input wire [1:0] retSel;
    output reg retTargetValid;
    output reg retTargetTag;
    output reg [`CAP_WIDTH-1:0] retTargetCap;
    output wire ddcTag;
    output wire [`CAP_WIDTH-1:0] ddcCap;

    reg [`CAP_WIDTH-1:0] capMem [0:`CAP_ENTRIES-1];
    reg [`CAP_ENTRIES-1:0] tagMem;
    reg [3:0] idx;
    reg isScratch;
    reg isExecPc;
    reg isVector;
    reg fullStore;
    reg needSysReg;
    reg isDebugReg;
    reg [`CAP_WIDTH-1:0] oldCap;
    reg oldTag;
    reg wideAccess;
    reg [`XLEN-1:0] operand;
    reg [`XLEN-1:0] narrowAddr;
    reg replSrcTag;
    reg [`CAP_WIDTH-1:0] replSrcCap;
    reg [`XLEN-1:0] replAddr;
    reg newTag;
    reg [`CAP_WIDTH-1:0] newCap;
    reg [`CAP_WIDTH-1:0] readCap;
    reg readTag;
    reg accessIllegal;
    reg writeTaken;
    reg instrIllegalNext;
    reg [3:0] retIdx;
    wire replTag;
    wire [`CAP_WIDTH-1:0] replCap;
    wire replChanged;
    wire vecInRange;
    integer i;

    // Address decode into a storage index
    always @* begin
        case (csrAddr)
            `ADDR_JUMP_TABLE_BASE_CAP: idx = `IDX_JVT;
            `ADDR_MACHINE_TRAP_VECTOR_CAP: idx = `IDX_MTVEC;
            `ADDR_SUPERVISOR_TRAP_VECTOR_CAP: idx = `IDX_STVEC;
            `ADDR_SUPERVISOR_SCRATCH_CAP: idx = `IDX_SSCRATCH;
            `ADDR_SUPERVISOR_EXCEPTION_PC_CAP: idx = `IDX_SEPC;
            `ADDR_SUPERVISOR_TRAP_DATA_CAP: idx = `IDX_STDC;
            `ADDR_MACHINE_SCRATCH_CAP: idx = `IDX_MSCRATCH;
            `ADDR_MACHINE_EXCEPTION_PC_CAP: idx = `IDX_MEPC;
            `ADDR_DEFAULT_DATA_CAP: idx = `IDX_DDC;
            `ADDR_MACHINE_TRAP_DATA_CAP: idx = `IDX_MTDC;
            `ADDR_DEBUG_PC_CAP: idx = `IDX_DPC;
            `ADDR_DEBUG_SCRATCH0_CAP: idx = `IDX_DSCRATCH0;
            `ADDR_DEBUG_SCRATCH1_CAP: idx = `IDX_DSCRATCH1;
            `ADDR_DEBUG_SAVED_DATA_CAP: idx = `IDX_DDDC;
            `ADDR_DEBUG_INFINITE_SOURCE_CAP: idx = `IDX_DINF;
            default: idx = `IDX_NONE;
        endcase
    end

    // Register classes
    always @* begin
        isExecPc = (idx == `IDX_JVT) || (idx == `IDX_SEPC) || (idx == `IDX_MEPC) || (idx == `IDX_DPC);
        isVector = (idx == `IDX_MTVEC) || (idx == `IDX_STVEC);
        isScratch = !isExecPc && !isVector && (idx != `IDX_DINF) && (idx != `IDX_NONE);
        fullStore = (idx == `IDX_SSCRATCH) || (idx == `IDX_MSCRATCH) ||
            (idx == `IDX_DSCRATCH0) || (idx == `IDX_DSCRATCH1);
        needSysReg = (idx == `IDX_MTVEC) || (idx == `IDX_STVEC) || (idx == `IDX_SSCRATCH) ||
            (idx == `IDX_SEPC) || (idx == `IDX_STDC) || (idx == `IDX_MSCRATCH) ||
            (idx == `IDX_MEPC) || (idx == `IDX_MTDC);
        isDebugReg = (idx >= `IDX_DPC) && (idx != `IDX_NONE);
    end

    // Current contents and read value
    always @* begin
        oldCap = {`CAP_WIDTH{1'b0}};
        oldTag = 1'b0;
        if (idx < `IDX_DINF) begin
            oldCap = capMem[idx];
            oldTag = tagMem[idx];
        end
        readCap = oldCap;
        readTag = oldTag;
        if (idx == `IDX_DINF) begin
            readCap = `CAP_INFINITE; // [R14]
            readTag = 1'b1; // [R14]
        end
        if (isExecPc && (idx != `IDX_JVT) && !compressedEnable) begin
            readCap[1] = 1'b0; // [R8]
        end
    end

    // Access width and narrow operand
    always @* begin
        wideAccess = csrWide && (csrOp == `CSR_OP_RW); // [R9] [R10]
        if ((csrOp == `CSR_OP_RWI) || (csrOp == `CSR_OP_RSI) || (csrOp == `CSR_OP_RCI)) begin
            operand = {27'h0, csrWdata[4:0]};
        end else begin
            operand = csrWdata[`XLEN-1:0];
        end
        case (csrOp)
            `CSR_OP_RS, `CSR_OP_RSI: narrowAddr = oldCap[`XLEN-1:0] | operand; // [R10]
            `CSR_OP_RC, `CSR_OP_RCI: narrowAddr = oldCap[`XLEN-1:0] & ~operand; // [R10]
            default: narrowAddr = operand;
        endcase
    end

    // Address replace source: stored value on narrow writes, written value on wide
    always @* begin
        if (wideAccess) begin
            replSrcTag = csrWtag;
            replSrcCap = csrWdata;
            replAddr = csrWdata[`XLEN-1:0];
        end else begin
            replSrcTag = oldTag;
            replSrcCap = oldCap;
            replAddr = narrowAddr;
        end
    end

    cap_addr_replace replaceUnit (
        .srcTag(replSrcTag),
        .srcCap(replSrcCap),
        .newAddr(replAddr),
        .convertEn(isExecPc || isVector), // [R11]
        .resultTag(replTag),
        .resultCap(replCap),
        .addrChanged(replChanged)
    );

    vec_range_check rangeUnit (
        .vecCap(replCap),
        .inRange(vecInRange)
    );

    // Value to store, per register class
    always @* begin
        newTag = replTag;
        newCap = replCap;
        if (isScratch && wideAccess) begin
            newTag = csrWtag; // [R1]
            newCap = csrWdata; // [R1]
        end else if (isExecPc && wideAccess && !replChanged) begin
            newTag = csrWtag; // [R3]
            newCap = csrWdata; // [R3]
        end
        if (isVector && (replCap[1:0] == `TVEC_MODE_VECTORED) && !vecInRange) begin
            newTag = 1'b0; // [R4] [R5]
        end
        if (!fullStore) begin
            newCap = newCap & ~`CAP_RESERVED_MASK; // [R12]
        end
        if (!`LEGACY_PRESENT) begin
            newCap[`CAP_MODE_BIT] = 1'b0; // [R16]
        end
    end

    // Privilege and permission checks for CSR access
    always @* begin
        accessIllegal = 1'b0;
        if (idx != `IDX_NONE) begin
            if (isDebugReg && !debugMode) begin
                accessIllegal = 1'b1; // [R19]
            end
            // Machine trap vector sits in a low address block but is machine only
            if (!debugMode && ((priv < csrAddr[9:8]) || ((idx == `IDX_MTVEC) && (priv != `PRIV_M)))) begin
                accessIllegal = 1'b1; // [R19]
            end
            if (needSysReg && !pccSysRegPerm) begin
                accessIllegal = 1'b1; // [R19]
            end
            if (!`LEGACY_PRESENT && !wideAccess && csrWriteEn) begin
                accessIllegal = 1'b1; // [R7]
            end
        end
        writeTaken = csrValid && csrWriteEn && !accessIllegal && (idx < `IDX_DINF); // [R14] [R19]
    end

    // Illegal instruction detect for return, cache block and mode instructions
    always @* begin
        instrIllegalNext = 1'b0;
        case (instrKind)
            `INSTR_SRET: begin
                instrIllegalNext = (priv < `PRIV_S) || !pccSysRegPerm ||
                    (trapSupervisorReturn && (priv == `PRIV_S)); // [R17]
            end
            `INSTR_CBO: begin
                instrIllegalNext = ((priv < `PRIV_M) && !machineCacheBlockInvalidateEnable) ||
                    ((priv < `PRIV_S) && !supervisorCacheBlockInvalidateEnable); // [R18]
            end
            `INSTR_MODE_SET, `INSTR_MODE_SWITCH: begin
                instrIllegalNext = !`LEGACY_PRESENT; // [R16]
            end
            default: instrIllegalNext = 1'b0;
        endcase
    end

    // Return target selection
    always @* begin
        case (retSel)
            `RET_MACHINE: retIdx = `IDX_MEPC;
            `RET_SUPERVISOR: retIdx = `IDX_SEPC;
            `RET_DEBUG: retIdx = `IDX_DPC;
            default: retIdx = `IDX_MEPC;
        endcase
    end

    // Storage update
    always @(posedge clock) begin
        if (rst) begin
            for (i = 0; i < `CAP_ENTRIES; i = i + 1) begin
                capMem[i] <= {`CAP_WIDTH{1'b0}};
                tagMem[i] <= 1'b0; // [R20]
            end
            capMem[`IDX_MTVEC] <= `CAP_INFINITE; // [R20]
            capMem[`IDX_STVEC] <= `CAP_INFINITE; // [R20]
            capMem[`IDX_MEPC] <= `CAP_INFINITE; // [R20]
            capMem[`IDX_SEPC] <= `CAP_INFINITE; // [R20]
            capMem[`IDX_DDC] <= `CAP_INFINITE; // [R20]
            tagMem[`IDX_MTVEC] <= 1'b1;
            tagMem[`IDX_STVEC] <= 1'b1;
            tagMem[`IDX_MEPC] <= 1'b1;
            tagMem[`IDX_SEPC] <= 1'b1;
            tagMem[`IDX_DDC] <= 1'b1;
        end else begin
            if (writeTaken) begin
                capMem[idx] <= newCap; // [R2]
                tagMem[idx] <= newTag; // [R2]
            end
            if (debugEntry) begin
                capMem[`IDX_DDDC] <= capMem[`IDX_DDC]; // [R15]
                tagMem[`IDX_DDDC] <= tagMem[`IDX_DDC]; // [R15]
            end else if (debugExit) begin
                capMem[`IDX_DDC] <= capMem[`IDX_DDDC]; // [R15]
                tagMem[`IDX_DDC] <= tagMem[`IDX_DDDC]; // [R15]
            end
        end
    end

    // Registered answers
    always @(posedge clock) begin
        if (rst) begin
            csrDone <= 1'b0;
            csrIllegal <= 1'b0;
            csrRtag <= 1'b0;
            csrRdata <= {`CAP_WIDTH{1'b0}};
            instrIllegal <= 1'b0;
            retTargetValid <= 1'b0;
            retTargetTag <= 1'b0;
            retTargetCap <= {`CAP_WIDTH{1'b0}};
        end else begin
            csrDone <= csrValid;
            csrIllegal <= csrValid && accessIllegal; // [R19]
            if (csrValid && !accessIllegal) begin
                csrRtag <= wideAccess ? readTag : 1'b0;
                csrRdata <= wideAccess ? readCap : {32'h00000000, readCap[`XLEN-1:0]};
            end
            instrIllegal <= instrValid && instrIllegalNext;
            retTargetValid <= retValid;
            if (retValid) begin
                retTargetTag <= tagMem[retIdx];
                retTargetCap <= capMem[retIdx];
                retTargetCap[`CAP_SEALED_BIT] <= 1'b0; // [R13]
                if (!compressedEnable) begin
                    retTargetCap[1] <= 1'b0; // [R8]
                end
            end
        end
    end

    assign ddcTag = tagMem[`IDX_DDC];
    assign ddcCap = capMem[`IDX_DDC];
endmodule

// File: core_model.sv
// Core-side model that issues CSR instructions to the bank
module core_model (
    input wire logic clock,
    input wire logic csrDone,
    input wire logic csrIllegal,
    input wire logic csrRtag,
    input wire logic [63:0] csrRdata,
    output logic csrValid,
    output logic csrWide,
    output logic csrWriteEn,
    output logic csrWtag,
    output logic [11:0] csrAddr,
    output logic [2:0] csrOp,
    output logic [63:0] csrWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rDone, rIll, rTag;
    logic [63:0] rData;
    initial begin
        csrValid = 1'b0;
        csrWide = 1'b0;
        csrWriteEn = 1'b0;
        csrWtag = 1'b0;
        csrAddr = 12'h000;
        csrOp = 3'h1;
        csrWdata = 64'h0;
    end
    // One request held over its taking edge; answer sampled in the next cycle
    task automatic access(input logic [11:0] a, input logic [2:0] op, input logic w, we, t,
                          input logic [63:0] d);
        @(posedge clock);
        csrValid <= 1'b1;
        csrAddr <= a;
        csrOp <= op;
        csrWide <= w;
        csrWriteEn <= we;
        csrWtag <= t;
        csrWdata <= d;
        @(posedge clock);
        csrValid <= 1'b0;
        csrWtag <= ~t;
        csrWdata <= ~d;
        @(negedge clock);
        rDone = csrDone;
        rIll = csrIllegal;
        rTag = csrRtag;
        rData = csrRdata;
    endtask
endmodule

// File: capability_width_csr_bank_monitor.sv
// Concurrent checks on the ports of the CSR bank
`include "cap_csr_defs.vh"
module capability_width_csr_bank_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] priv,
    input wire logic debugMode,
    input wire logic pccSysRegPerm,
    input wire logic csrValid,
    input wire logic [11:0] csrAddr,
    input wire logic [2:0] csrOp,
    input wire logic csrWide,
    input wire logic csrDone,
    input wire logic csrIllegal,
    input wire logic csrRtag,
    input wire logic [63:0] csrRdata,
    input wire logic instrValid,
    input wire logic [2:0] instrKind,
    input wire logic machineCacheBlockInvalidateEnable,
    input wire logic instrIllegal,
    input wire logic retValid,
    input wire logic retTargetValid,
    input wire logic [63:0] retTargetCap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    done_timing_a: assert property (csrValid |=> csrDone) else $error("answer missing");
    done_cause_a: assert property (csrDone |-> $past(csrValid)) else $error("stray answer");
    priv_refuse_a: assert property (csrValid && !debugMode && priv == `PRIV_U
        && csrAddr == `ADDR_MACHINE_SCRATCH_CAP |=> csrIllegal) else $error("privilege not refused");
    perm_refuse_a: assert property (csrValid && !debugMode && !pccSysRegPerm
        && csrAddr == `ADDR_MACHINE_EXCEPTION_PC_CAP |=> csrIllegal) else $error("permission not refused");
    narrow_read_a: assert property (csrValid && (!csrWide || csrOp != `CSR_OP_RW)
        |=> csrIllegal || (!csrRtag && csrRdata[63:32] == 32'h0)) else $error("narrow read wide");
    inf_read_a: assert property (csrValid && debugMode && csrWide && csrOp == `CSR_OP_RW
        && csrAddr == `ADDR_DEBUG_INFINITE_SOURCE_CAP |=> csrRtag && csrRdata == `CAP_INFINITE)
        else $error("infinite source wrong");
    sret_low_a: assert property (instrValid && instrKind == `INSTR_SRET && priv == `PRIV_U
        |=> instrIllegal) else $error("return not refused");
    cbo_enable_a: assert property (instrValid && instrKind == `INSTR_CBO && priv == `PRIV_S
        && !machineCacheBlockInvalidateEnable |=> instrIllegal) else $error("cache op not refused");
    mode_set_a: assert property (instrValid && instrKind == `INSTR_MODE_SET |=> !instrIllegal)
        else $error("mode set refused");
    ret_unseal_a: assert property (retValid |=> retTargetValid && !retTargetCap[`CAP_SEALED_BIT])
        else $error("return target sealed");
    cover property (csrValid ##1 csrIllegal);
    cover property (instrValid ##1 instrIllegal);
    cover property (retValid ##1 retTargetValid);
endmodule

bind capability_width_csr_bank capability_width_csr_bank_monitor mon (.*);

// File: capability_width_csr_bank_tb.sv
// Self-checking bench for the capability-width CSR bank
`include "cap_csr_defs.vh"
module capability_width_csr_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, debugMode = 1'b0, pccSysRegPerm = 1'b1, compressedEnable = 1'b1;
    logic [1:0] priv = `PRIV_M, retSel = `RET_MACHINE;
    logic instrValid = 1'b0, trapSupervisorReturn = 1'b0, debugEntry = 1'b0, debugExit = 1'b0;
    logic machineCacheBlockInvalidateEnable = 1'b0, supervisorCacheBlockInvalidateEnable = 1'b0;
    logic [2:0] instrKind = 3'h0, csrOp;
    logic retValid = 1'b0, csrValid, csrWide, csrWriteEn, csrWtag, csrDone, csrIllegal, csrRtag;
    logic instrIllegal, retTargetValid, retTargetTag, ddcTag;
    logic [11:0] csrAddr;
    logic [63:0] csrWdata, csrRdata, retTargetCap, ddcCap;
    localparam logic [63:0] INF = `CAP_INFINITE;
    localparam logic [63:0] DSCR = INF | 64'h8000_0000_0000_1234;
    localparam logic [63:0] DDAT = INF | 64'h0000_0000_0000_4000;
    int err_count = 0, n_checks = 0, cycles = 0;
    capability_width_csr_bank dut (.*);
    core_model core (.*);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [64:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [2:0] op, input logic w, input logic [64:0] e);
        core.access(a, op, w, 1'b0, 1'b0, 64'h0);
        chk("read", e, {core.rTag, core.rData});
    endtask
    task automatic wr(input logic [11:0] a, input logic w, input logic [64:0] v);
        core.access(a, `CSR_OP_RW, w, 1'b1, v[64], v[63:0]);
    endtask
    task automatic t_reset();
        rd(`ADDR_MACHINE_TRAP_VECTOR_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF});
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RW, 1'b1, 65'h0);
        chk("ddc", {1'b1, INF}, {ddcTag, ddcCap});
    endtask
    task automatic t_scratch();
        wr(`ADDR_MACHINE_SCRATCH_CAP, 1'b1, {1'b1, DSCR});
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RW, 1'b1, {1'b1, DSCR});
        wr(`ADDR_MACHINE_SCRATCH_CAP, 1'b0, 65'h5678);
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RW, 1'b1, {1'b1, DSCR[63:32], 32'h5678});
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RW, 1'b0, 65'h5678);
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RS, 1'b1, 65'h5678);
    endtask
    task automatic t_priv();
        priv <= `PRIV_U;
        wr(`ADDR_MACHINE_SCRATCH_CAP, 1'b1, 65'h0);
        chk("illegal", 65'h1, {64'h0, core.rIll});
        priv <= `PRIV_S;
        wr(`ADDR_MACHINE_TRAP_VECTOR_CAP, 1'b1, 65'h0);
        chk("illegal", 65'h1, {64'h0, core.rIll});
        priv <= `PRIV_M;
        pccSysRegPerm <= 1'b0;
        wr(`ADDR_MACHINE_EXCEPTION_PC_CAP, 1'b1, 65'h0);
        chk("illegal", 65'h1, {64'h0, core.rIll});
        pccSysRegPerm <= 1'b1;
        rd(`ADDR_MACHINE_SCRATCH_CAP, `CSR_OP_RW, 1'b1, {1'b1, DSCR[63:32], 32'h5678});
        rd(`ADDR_MACHINE_EXCEPTION_PC_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF});
        rd(`ADDR_MACHINE_TRAP_VECTOR_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF});
    endtask
    task automatic t_epc();
        wr(`ADDR_MACHINE_EXCEPTION_PC_CAP, 1'b1, {1'b1, INF | 64'h8000_0100});
        rd(`ADDR_MACHINE_EXCEPTION_PC_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF | 64'h0100});
        wr(`ADDR_MACHINE_EXCEPTION_PC_CAP, 1'b0, 65'h4000_0200);
        rd(`ADDR_MACHINE_EXCEPTION_PC_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF | 64'hc000_0200});
        wr(`ADDR_MACHINE_EXCEPTION_PC_CAP, 1'b1, {1'b1, INF | 64'h0008_0000_0000_0102});
        compressedEnable <= 1'b0;
        rd(`ADDR_MACHINE_EXCEPTION_PC_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF | 64'h0008_0000_0000_0100});
        @(posedge clock);
        retValid <= 1'b1;
        @(posedge clock);
        retValid <= 1'b0;
        @(negedge clock);
        chk("ret", {1'b1, INF | 64'h0100}, {retTargetTag, retTargetCap});
        compressedEnable <= 1'b1;
    endtask
    task automatic t_vec();
        wr(`ADDR_MACHINE_TRAP_VECTOR_CAP, 1'b1, {1'b1, 64'h0002_4000_0000_0001});
        rd(`ADDR_MACHINE_TRAP_VECTOR_CAP, `CSR_OP_RW, 1'b1, {1'b1, 64'h0002_4000_0000_0001});
        wr(`ADDR_MACHINE_TRAP_VECTOR_CAP, 1'b0, 65'h101);
        rd(`ADDR_MACHINE_TRAP_VECTOR_CAP, `CSR_OP_RW, 1'b1, {1'b0, 64'h0002_4000_0000_0101});
    endtask
    task automatic t_debug();
        debugMode <= 1'b1;
        wr(`ADDR_DEBUG_INFINITE_SOURCE_CAP, 1'b1, 65'h0);
        rd(`ADDR_DEBUG_INFINITE_SOURCE_CAP, `CSR_OP_RW, 1'b1, {1'b1, INF});
        wr(`ADDR_DEFAULT_DATA_CAP, 1'b1, {1'b1, DDAT});
        @(posedge clock);
        debugEntry <= 1'b1;
        @(posedge clock);
        debugEntry <= 1'b0;
        rd(`ADDR_DEBUG_SAVED_DATA_CAP, `CSR_OP_RW, 1'b1, {1'b1, DDAT});
        wr(`ADDR_DEFAULT_DATA_CAP, 1'b1, 65'h0);
        @(posedge clock);
        debugExit <= 1'b1;
        @(posedge clock);
        debugExit <= 1'b0;
        @(negedge clock);
        chk("ddc", {1'b1, DDAT}, {ddcTag, ddcCap});
        debugMode <= 1'b0;
    endtask
    // Kind, privilege, supervisor-return trap, M enable, S enable, permission, expected refusal
    logic [9:0] cases [10] = '{10'b001_00_00011, 10'b001_01_00010, 10'b001_01_10011, 10'b001_11_00001,
        10'b010_00_01001, 10'b010_00_01110, 10'b010_01_00111, 10'b010_11_00000, 10'b011_11_00010,
        10'b100_11_00010};
    task automatic t_instr();
        foreach (cases[i]) begin
            @(posedge clock);
            {instrKind, priv, trapSupervisorReturn, machineCacheBlockInvalidateEnable} <= cases[i][9:3];
            {supervisorCacheBlockInvalidateEnable, pccSysRegPerm} <= cases[i][2:1];
            instrValid <= 1'b1;
            @(posedge clock);
            instrValid <= 1'b0;
            @(negedge clock);
            chk("instr", {64'h0, cases[i][0]}, {64'h0, instrIllegal});
        end
        priv <= `PRIV_M;
        pccSysRegPerm <= 1'b1;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_scratch();
        t_priv();
        t_epc();
        t_vec();
        t_debug();
        t_instr();
        conclude();
    end
endmodule
